// ==== logic/ufis_irq_bit.sv ====
// One write-zero-to-clear interrupt flag with optional clock-stopped clear deferral
`timescale 1ns/10ps
`default_nettype none
module ufis_irq_bit
    import ufis_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic soft_rst,
    input  wire logic set_evt,
    input  wire logic clr_wr,
    input  wire logic one_wr,
    input  wire logic clk_running,
    output logic      flag
);
    ufis_clr_state_t pend_r;
    logic            do_clr;

    // ------------------------------------------------------------------------
    // Deferred clear
    // ------------------------------------------------------------------------
    // With the core clock stopped a zero only arms the clear; the later one
    // releases it, so a single stray zero cannot lose an event.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= UFIS_CLR_IDLE;
        end else if (soft_rst || clk_running) begin
            pend_r <= UFIS_CLR_IDLE;
        end else begin
            case (pend_r)
                UFIS_CLR_IDLE: if (clr_wr) pend_r <= UFIS_CLR_PEND;
                UFIS_CLR_PEND: if (one_wr) pend_r <= UFIS_CLR_IDLE;
                default:       pend_r <= UFIS_CLR_IDLE;
            endcase
        end
    end

    assign do_clr = clk_running ? clr_wr : (pend_r == UFIS_CLR_PEND && one_wr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (soft_rst) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (do_clr) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== logic/ufis_top.sv ====
// Top-level interrupt status word of a USB function controller, APB slave
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "ufis_params.svh"
module ufis_top
    import ufis_pkg::*;
#(
    parameter int NUM_PIPES = 7
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 vbus_pin,
    input  wire logic                 core_clk_running,
    input  wire logic                 resume_evt,
    input  wire logic                 usb_bus_reset,
    input  wire logic                 dev_state_evt,
    input  wire logic [2:0]           dev_state_in,
    input  wire logic                 ctrl_stage_evt,
    input  wire logic [2:0]           ctrl_stage_in,
    input  wire logic                 setup_rcvd,
    input  wire logic [NUM_PIPES-1:0] pipe_empty_or_size_error_flag,
    input  wire logic [NUM_PIPES-1:0] pipe_not_ready_flag,
    input  wire logic [NUM_PIPES-1:0] pipe_ready_flag,
    output logic                      irq
);
    if (NUM_PIPES < 1 || NUM_PIPES > 16) begin : g_bad_pipes
        $error("NUM_PIPES must be 1..16");
    end

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    logic wr_acc;
    logic hit_stat;
    logic hit_en;
    logic hit_mask;
    logic hit_srst;
    logic lo_en;
    logic hi_en;
    logic soft_rst;

    assign pready   = 1'b1;
    assign wr_acc   = psel && penable && pwrite;
    assign hit_stat = (paddr == `UFIS_OFF_STATUS);
    assign hit_en   = (paddr == `UFIS_OFF_EMPTY_EN);
    assign hit_mask = (paddr == `UFIS_OFF_IRQ_MASK);
    assign hit_srst = (paddr == `UFIS_OFF_SW_RESET);
    assign pslverr  = psel && penable && !(hit_stat || hit_en || hit_mask || hit_srst);
    assign lo_en    = pstrb[0];
    assign hi_en    = pstrb[1];
    assign soft_rst = wr_acc && hit_srst && lo_en && pwdata[0];

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    logic [NUM_PIPES-1:0] empty_en_r;
    logic [15:0]          mask_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_en_r <= '0;
        end else if (soft_rst) begin
            empty_en_r <= '0;
        end else if (wr_acc && hit_en && lo_en) begin
            empty_en_r <= pwdata[NUM_PIPES-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `UFIS_RST_ZERO16;
        end else if (wr_acc && hit_mask) begin
            if (lo_en) mask_r[7:0] <= pwdata[7:0];
            if (hi_en) mask_r[15:8] <= pwdata[15:8];
        end
    end

    // ------------------------------------------------------------------------
    // VBUS level and change detect
    // ------------------------------------------------------------------------
    logic vbus_prev_r;
    logic vbus_seen_r;
    logic vbus_chg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbus_prev_r <= 1'b0;
            vbus_seen_r <= 1'b0;
        end else begin
            vbus_prev_r <= vbus_pin;
            vbus_seen_r <= 1'b1;
        end
    end

    // No compare on the first edge after reset: a pin already high is no change
    assign vbus_chg = vbus_seen_r && (vbus_pin != vbus_prev_r);

    // ------------------------------------------------------------------------
    // Writable interrupt flags
    // ------------------------------------------------------------------------
    logic stat_wr_hi;
    logic stat_wr_lo;
    logic vbus_irq;
    logic resume_irq;

    assign stat_wr_hi = wr_acc && hit_stat && hi_en;
    assign stat_wr_lo = wr_acc && hit_stat && lo_en;

    ufis_irq_bit u_vbus (
        .clk         (pclk),
        .rst_n       (presetn),
        .soft_rst    (soft_rst),
        .set_evt     (vbus_chg),
        .clr_wr      (stat_wr_hi && !pwdata[`UFIS_B_VBUS_IRQ]),
        .one_wr      (stat_wr_hi && pwdata[`UFIS_B_VBUS_IRQ]),
        .clk_running (core_clk_running),
        .flag        (vbus_irq)
    );

    ufis_irq_bit u_resume (
        .clk         (pclk),
        .rst_n       (presetn),
        .soft_rst    (soft_rst),
        .set_evt     (resume_evt),
        .clr_wr      (stat_wr_hi && !pwdata[`UFIS_B_RESUME_IRQ]),
        .one_wr      (stat_wr_hi && pwdata[`UFIS_B_RESUME_IRQ]),
        .clk_running (core_clk_running),
        .flag        (resume_irq)
    );

    logic             device_state_change_irq_irq_r;
    logic             ctst_irq_r;
    logic             setup_r;
    ufis_dev_state_t  device_state_field_r;
    ufis_ctrl_stage_t control_stage_field_r;

    // Clears need the core clock; writes of one never set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_state_change_irq_irq_r <= 1'b0;
        end else if (soft_rst) begin
            device_state_change_irq_irq_r <= 1'b0;
        end else if (dev_state_evt || usb_bus_reset) begin
            device_state_change_irq_irq_r <= 1'b1;
        end else if (stat_wr_hi && core_clk_running && !pwdata[`UFIS_B_DEVICE_STATE_CHANGE_IRQ_IRQ]) begin
            device_state_change_irq_irq_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctst_irq_r <= 1'b0;
        end else if (soft_rst) begin
            ctst_irq_r <= 1'b0;
        end else if (ctrl_stage_evt) begin
            ctst_irq_r <= 1'b1;
        end else if (stat_wr_hi && core_clk_running && !pwdata[`UFIS_B_CTST_IRQ]) begin
            ctst_irq_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_r <= 1'b0;
        end else if (soft_rst) begin
            setup_r <= 1'b0;
        end else if (setup_rcvd) begin
            setup_r <= 1'b1;
        end else if (stat_wr_lo && core_clk_running && !pwdata[`UFIS_B_SETUP]) begin
            setup_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // State fields, not writable from the bus
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_state_field_r <= UFIS_DS_POWERED;
        end else if (soft_rst) begin
            device_state_field_r <= UFIS_DS_POWERED;
        end else if (usb_bus_reset) begin
            device_state_field_r <= UFIS_DS_DEFAULT;
        end else if (dev_state_evt) begin
            case (dev_state_in[2])
                1'b1:    device_state_field_r <= UFIS_DS_SUSPENDED;
                default: device_state_field_r <= ufis_dev_state_t'(dev_state_in);
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_stage_field_r <= UFIS_CS_IDLE_SETUP;
        end else if (soft_rst) begin
            control_stage_field_r <= UFIS_CS_IDLE_SETUP;
        end else if (ctrl_stage_evt) begin
            control_stage_field_r <= ufis_ctrl_stage_t'(ctrl_stage_in);
        end
    end

    // ------------------------------------------------------------------------
    // Summary buffer bits
    // ------------------------------------------------------------------------
    logic [NUM_PIPES-1:0] empty_gated;

    generate
        for (genvar i = 0; i < NUM_PIPES; i++) begin : g_pipe
            assign empty_gated[i] = pipe_empty_or_size_error_flag[i] && empty_en_r[i];
        end
    endgenerate

    logic empty_sum;
    logic nrdy_sum;
    logic rdy_sum;
    // Derived live from the per-pipe flags: clears as soon as all flags clear
    assign empty_sum = |empty_gated;
    assign nrdy_sum  = |pipe_not_ready_flag;
    assign rdy_sum   = |pipe_ready_flag;

    // ------------------------------------------------------------------------
    // Status word, read data and interrupt
    // ------------------------------------------------------------------------
    logic [15:0] status;

    assign status = {vbus_irq, resume_irq, 1'b0, device_state_change_irq_irq_r, ctst_irq_r,
                     empty_sum, nrdy_sum, rdy_sum,
                     vbus_pin, device_state_field_r, setup_r, control_stage_field_r};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_stat) prdata <= {16'h0000, status};
            else if (hit_en) prdata <= {{(32-NUM_PIPES){1'b0}}, empty_en_r};
            else if (hit_mask) prdata <= {16'h0000, mask_r};
            else prdata <= 32'h00000000;
        end
    end

    assign irq = |(status & mask_r & `UFIS_IRQ_BITS_MASK);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_empty_gate;
        @(posedge pclk) disable iff (!presetn)
        (empty_en_r == '0) |-> !status[`UFIS_B_EMPTY];
    endproperty
    a_empty_gate: assert property (p_empty_gate) else $error("empty summary set while all disabled");

    property p_rsvd_zero;
        @(posedge pclk) disable iff (!presetn)
        !status[`UFIS_B_RSVD];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one");

    property p_one_no_clear;
        @(posedge pclk) disable iff (!presetn)
        (stat_wr_hi && pwdata[`UFIS_B_VBUS_IRQ] && vbus_irq && core_clk_running && !soft_rst)
            |=> vbus_irq;
    endproperty
    a_one_no_clear: assert property (p_one_no_clear) else $error("write one cleared vbus irq");

    sequence s_zero_stopped;
        stat_wr_hi && !pwdata[`UFIS_B_RESUME_IRQ] && !core_clk_running && !soft_rst && !resume_evt;
    endsequence
    property p_stopped_clear;
        @(posedge pclk) disable iff (!presetn)
        s_zero_stopped ##0 resume_irq |=> resume_irq;
    endproperty
    a_stopped_clear: assert property (p_stopped_clear) else $error("lone zero cleared resume");

    property p_device_state_change_irq_clear;
        @(posedge pclk) disable iff (!presetn)
        (stat_wr_hi && core_clk_running && !pwdata[`UFIS_B_DEVICE_STATE_CHANGE_IRQ_IRQ] && !dev_state_evt
            && !usb_bus_reset) |=> !device_state_change_irq_irq_r;
    endproperty
    a_device_state_change_irq_clear: assert property (p_device_state_change_irq_clear) else $error("state irq not cleared");

    property p_bus_reset;
        @(posedge pclk) disable iff (!presetn)
        (usb_bus_reset && !soft_rst) |=> device_state_change_irq_irq_r && device_state_field_r == UFIS_DS_DEFAULT;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("bus reset effect missing");

    property p_soft_reset;
        @(posedge pclk) disable iff (!presetn)
        soft_rst |=> (status & 16'hFF7F) == {5'h00, empty_sum, nrdy_sum, rdy_sum, 8'h00};
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset left bits set");

    property p_setup;
        @(posedge pclk) disable iff (!presetn)
        (setup_rcvd && !soft_rst) |=> setup_r [*1] ##0 status[`UFIS_B_SETUP];
    endproperty
    a_setup: assert property (p_setup) else $error("setup flag not set");

    property p_vbus_chg;
        @(posedge pclk) disable iff (!presetn)
        ($changed(vbus_pin) && !soft_rst) |=> vbus_irq;
    endproperty
    a_vbus_chg: assert property (p_vbus_chg) else $error("vbus change not flagged");
endmodule
`default_nettype wire

// ==== shared/ufis_params.svh ====
// Offsets, field positions and reset values for the USB function status block
// Notes on behaviour
// - Per-pipe enable gates empty flag into summary
// - Sixteen-bit status word at offset 0x60
// - VBUS/resume irq: write 0 clears, 1 ignored
// - Clock stopped: write 0 arms clear, later write 1 performs it
// - Bit 13 reserved, reads zero
// - State/stage irq: write 0 clears only
// - Summary buffer bits read-only, writes ignored
// - Device state encoding, writes ignored
// - Bus reset sets state irq, state default
// - Hard/soft reset zero all but VBUS level and ready/not-ready summaries; soft reset keeps mask
// - Setup flag: set on setup, write 0 clears
// - Control stage field read-only, encoded stages
// - Empty summary set by any enabled flag
// - Not-ready summary follows status register 2
// - Ready summary follows status register 1
// - VBUS level mirrors pin, change sets irq
`ifndef UFIS_PARAMS_SVH
`define UFIS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UFIS_OFF_STATUS     12'h060
`define UFIS_OFF_EMPTY_EN   12'h04C
`define UFIS_OFF_IRQ_MASK   12'h070
`define UFIS_OFF_SW_RESET   12'h074

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UFIS_B_VBUS_IRQ     15
`define UFIS_B_RESUME_IRQ   14
`define UFIS_B_RSVD         13
`define UFIS_B_DEVICE_STATE_CHANGE_IRQ_IRQ     12
`define UFIS_B_CTST_IRQ     11
`define UFIS_B_EMPTY        10
`define UFIS_B_NRDY         9
`define UFIS_B_RDY          8
`define UFIS_B_VBUS_LVL     7
`define UFIS_B_SETUP        3
`define UFIS_IRQ_BITS_MASK  16'hDF08

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UFIS_RST_ZERO16     16'h0000
`define UFIS_RST_DEVICE_STATE_FIELD       3'h0
`define UFIS_BUSRST_DEVICE_STATE_FIELD    3'h1

`endif

// ==== shared/ufis_pkg.sv ====
// Types of the USB function status block
package ufis_pkg;
    typedef enum logic [2:0] {
        UFIS_DS_POWERED    = 3'h0,
        UFIS_DS_DEFAULT    = 3'h1,
        UFIS_DS_ADDRESS    = 3'h2,
        UFIS_DS_CONFIGURED = 3'h3,
        UFIS_DS_SUSPENDED  = 3'h4
    } ufis_dev_state_t;

    typedef enum logic [2:0] {
        UFIS_CS_IDLE_SETUP = 3'h0,
        UFIS_CS_RD_DATA    = 3'h1,
        UFIS_CS_RD_STATUS  = 3'h2,
        UFIS_CS_WR_DATA    = 3'h3,
        UFIS_CS_WR_STATUS  = 3'h4,
        UFIS_CS_NODATA_ST  = 3'h5,
        UFIS_CS_SEQ_ERROR  = 3'h6,
        UFIS_CS_RESERVED   = 3'h7
    } ufis_ctrl_stage_t;

    typedef enum {
        UFIS_CLR_IDLE,
        UFIS_CLR_PEND
    } ufis_clr_state_t;
endpackage

// ==== tb/ufis_top_tb.sv ====
// Self-checking testbench for the USB function status word block
`timescale 1ns/10ps
`default_nettype none
`include "ufis_params.svh"
module ufis_top_tb
    import ufis_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        vbus_pin;
    logic        core_clk_running;
    logic [4:0]  ev;
    logic [2:0]  dev_state_in;
    logic [2:0]  ctrl_stage_in;
    logic [6:0]  f_empty;
    logic [6:0]  f_nrdy;
    logic [6:0]  f_rdy;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    int          err_total;
    int          tests_run;
    int          cyc = 0;

    ufis_top #(.NUM_PIPES(7)) DUT (
        .pclk                          (pclk),
        .presetn                       (presetn),
        .psel                          (psel),
        .penable                       (penable),
        .pwrite                        (pwrite),
        .paddr                         (paddr),
        .pwdata                        (pwdata),
        .pstrb                         (pstrb),
        .prdata                        (prdata),
        .pready                        (pready),
        .pslverr                       (pslverr),
        .vbus_pin                      (vbus_pin),
        .core_clk_running              (core_clk_running),
        .resume_evt                    (ev[0]),
        .usb_bus_reset                 (ev[1]),
        .dev_state_evt                 (ev[2]),
        .dev_state_in                  (dev_state_in),
        .ctrl_stage_evt                (ev[3]),
        .ctrl_stage_in                 (ctrl_stage_in),
        .setup_rcvd                    (ev[4]),
        .pipe_empty_or_size_error_flag (f_empty),
        .pipe_not_ready_flag           (f_nrdy),
        .pipe_ready_flag               (f_rdy),
        .irq                           (irq)
    );

    // ------------------------------------------------------------------
    // Clock, timeout and closing report
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run needs well under 2000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
        chk("slverr", 32'h0000_0000, {31'h0, er});
    endtask

    task automatic st(input logic [15:0] exp);
        rd_chk(`UFIS_OFF_STATUS, {16'h0000, exp}, "status");
    endtask

    // irq is combinational from registers and the pipe flags, so look after the edge settles
    task automatic irq_chk(input logic exp);
        #1;
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask

    task automatic done_t(input string name);
        $display("Test %s done, mismatches so far %0d", name, err_total);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        vbus_pin = 1'b0;
        core_clk_running = 1'b1;
        ev = 5'h00;
        dev_state_in = 3'h0;
        ctrl_stage_in = 3'h0;
        f_empty = 7'h00;
        f_nrdy = 7'h00;
        f_rdy = 7'h00;
        err_total = 0;
        tests_run = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        st(16'h0000);
        rd_chk(`UFIS_OFF_IRQ_MASK, 32'h0000_0000, "mask");
        wr(`UFIS_OFF_STATUS, 32'h0000_DFFF);
        st(16'h0000);
        done_t("reset");
        vbus_pin <= 1'b1;
        settle();
        st(16'h8080);
        irq_chk(1'b0);
        wr(`UFIS_OFF_IRQ_MASK, 32'h0000_8000);
        irq_chk(1'b1);
        wr(`UFIS_OFF_STATUS, 32'h0000_DFFF);
        st(16'h8080);
        wr(`UFIS_OFF_STATUS, 32'h0000_5FFF);
        st(16'h0080);
        irq_chk(1'b0);
        vbus_pin <= 1'b0;
        settle();
        st(16'h8000);
        wr(`UFIS_OFF_STATUS, 32'h0000_5FFF);
        st(16'h0000);
        done_t("vbus");
        pulse(1);
        st(16'h1010);
        for (int i = 0; i < 8; i++) begin
            dev_state_in <= 3'(i);
            pulse(2);
            st(16'h1000 | 16'((i > 3 ? 4 : i) << 4));
            wr(`UFIS_OFF_STATUS, 32'h0000_CFFF);
        end
        for (int j = 0; j < 8; j++) begin
            ctrl_stage_in <= 3'(j);
            pulse(3);
            st(16'h0840 | 16'(j));
            wr(`UFIS_OFF_STATUS, 32'h0000_D7FF);
        end
        pulse(1);
        st(16'h1017);
        pulse(4);
        wr(`UFIS_OFF_STATUS, 32'h0000_DFFF);
        st(16'h101F);
        wr(`UFIS_OFF_STATUS, 32'h0000_0000);
        st(16'h0017);
        done_t("states");
        // Without the internal clock a zero only arms the clear
        core_clk_running <= 1'b0;
        pulse(0);
        pulse(4);
        wr(`UFIS_OFF_STATUS, 32'h0000_0000);
        st(16'h401F);
        wr(`UFIS_OFF_STATUS, 32'h0000_4000);
        st(16'h001F);
        core_clk_running <= 1'b1;
        wr(`UFIS_OFF_STATUS, 32'h0000_0000);
        st(16'h0017);
        done_t("clock stopped");
        wr(`UFIS_OFF_EMPTY_EN, 32'h0000_0000);
        f_empty <= 7'h7F;
        settle();
        st(16'h0017);
        for (int i = 0; i < 7; i++) begin
            f_empty <= 7'h7F & ~7'(1 << i);
            wr(`UFIS_OFF_EMPTY_EN, 32'(1 << i));
            rd_chk(`UFIS_OFF_EMPTY_EN, 32'(1 << i), "enable");
            st(16'h0017);
            f_empty <= 7'(1 << i);
            settle();
            st(16'h0417);
        end
        for (int i = 0; i < 7; i++) begin
            f_nrdy <= 7'(1 << i);
            f_rdy <= 7'(1 << (6 - i));
            settle();
            st(16'h0717);
        end
        wr(`UFIS_OFF_STATUS, 32'h0000_D8FF);
        st(16'h0717);
        f_empty <= 7'h00;
        f_nrdy <= 7'h00;
        f_rdy <= 7'h00;
        settle();
        st(16'h0017);
        done_t("summaries");
        apb(1'b1, 12'h100, 32'h0000_FFFF);
        chk("slverr", 32'h0000_0001, {31'h0, er});
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, er});
        chk("unmapped", 32'h0000_0000, rd);
        pulse(4);
        wr(`UFIS_OFF_SW_RESET, 32'h0000_0001);
        st(16'h0000);
        rd_chk(`UFIS_OFF_EMPTY_EN, 32'h0000_0000, "enable");
        rd_chk(`UFIS_OFF_IRQ_MASK, 32'h0000_8000, "mask");
        done_t("soft reset");
        end_sim();
    end
endmodule
`default_nettype wire
